// ### pkg/esr_regs.vh
// constants for the eight-bit shift register family
`ifndef ESR_REGS_VH
`define ESR_REGS_VH
`define ESR_WIDTH      8
`define ESR_RESET_VAL  8'h00
`define ESR_FIFO_DEPTH 8
`define ESR_FIFO_AW    3
`define ESR_OPT_SERIAL 2'h0
`define ESR_OPT_ASYNC  2'h1
`define ESR_OPT_SYNC   2'h2
`endif

// ### design/esr_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module esr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             reset,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             do_wr;
  wire             do_rd;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr && !do_rd) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ### design/esr_shift.v
// eight-stage shift register, three build options, parallel words buffered
`timescale 1ns/10ps
`default_nettype none
`include "esr_regs.vh"
module esr_shift #(
  parameter [1:0] OPTION    = `ESR_OPT_SYNC,
  parameter       HAS_CLEAR = 1
) (
  // clock and reset
  input  wire                  clk_sys,
  input  wire                  reset,
  // serial entry
  input  wire                  serial_gate_a,
  input  wire                  serial_gate_b,
  input  wire                  serial_data_in,
  // parallel word entry, buffered
  input  wire                  word_valid,
  output wire                  word_ready,
  input  wire [`ESR_WIDTH-1:0] word_data,
  // controls
  input  wire                  shift_enable,
  input  wire                  clear_n,
  input  wire                  clear_high,
  input  wire                  load_not_shift,
  input  wire                  clock_inhibit,
  input  wire                  shift_load_select,
  input  wire                  clock_hold,
  // stage outputs
  output wire [`ESR_WIDTH-1:0] stage_out,
  output wire [`ESR_WIDTH-1:0] stage_inverted_out,
  output wire                  first_stage_out,
  output wire                  last_stage_out
);
  localparam W = `ESR_WIDTH;

  reg  [W-1:0] stages;
  reg  [W-1:0] next_stages;
  reg          load_prev;
  wire [W-1:0] word_head;
  wire         word_avail;
  wire         entry_bit;
  wire         load_fall;
  wire         clear_now;
  wire         want_word;

  // buffer decouples the word source from the load moment
  esr_fifo #(
    .WIDTH (W),
    .DEPTH (`ESR_FIFO_DEPTH),
    .AW    (`ESR_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_data   (word_data),
    .out_valid (word_avail),
    .out_ready (want_word),
    .out_data  (word_head)
  );

  // serial-only takes the gated pair, the others the plain serial input
  assign entry_bit = (OPTION == `ESR_OPT_SERIAL) ?
                     (serial_gate_a & serial_gate_b) : serial_data_in;

  assign load_fall = load_prev & ~load_not_shift;

  // clear is a level; combined with the register so it shows at once
  assign clear_now = (OPTION == `ESR_OPT_ASYNC) ? (HAS_CLEAR != 0) & clear_high
                                                : ~clear_n;

  // a word is consumed only by the load that uses it
  assign want_word = ~clear_now & (
                     ((OPTION == `ESR_OPT_ASYNC) & load_fall) |
                     ((OPTION == `ESR_OPT_SYNC) & shift_enable &
                      ~shift_load_select & ~clock_hold));

  always @* begin
    next_stages = stages;
    case (OPTION)
      `ESR_OPT_SERIAL: begin
        if (shift_enable) begin
          next_stages = {stages[W-2:0], entry_bit};
        end
      end
      `ESR_OPT_ASYNC: begin
        if (load_fall) begin
          if (word_avail) begin
            next_stages = word_head;
          end
        end else if (shift_enable && load_not_shift && !clock_inhibit) begin
          next_stages = {stages[W-2:0], entry_bit};
        end
      end
      `ESR_OPT_SYNC: begin
        if (shift_enable && !clock_hold) begin
          if (!shift_load_select) begin
            if (word_avail) begin
              next_stages = word_head;
            end
          end else begin
            next_stages = {stages[W-2:0], entry_bit};
          end
        end
      end
      default: begin
        next_stages = stages;
      end
    endcase
    if (clear_now) begin
      next_stages = `ESR_RESET_VAL;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stages    <= `ESR_RESET_VAL;
      load_prev <= 1'b1;
    end else begin
      stages    <= next_stages;
      load_prev <= load_not_shift;
    end
  end

  // outputs follow clear in the same cycle
  assign stage_out          = clear_now ? `ESR_RESET_VAL : stages;
  assign stage_inverted_out = ~stage_out;
  assign first_stage_out    = stage_out[0];
  assign last_stage_out     = stage_out[W-1];
endmodule
`default_nettype wire

// ### bench/esr_chk.sv
// concurrent checks on the stage outputs
`timescale 1ns/10ps
`default_nettype none
module esr_chk (
  // clock, reset, controls
  input wire logic       clk_sys, reset, clear_n, shift_enable,
  input wire logic       shift_load_select, clock_hold, serial_data_in,
  // outputs watched
  input wire logic [7:0] stage_out, stage_inverted_out,
  input wire logic       first_stage_out, last_stage_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire sh = clear_n && shift_enable && shift_load_select && !clock_hold;
  inv_out_a: assert property (stage_inverted_out == ~stage_out) else $error("inv");
  first_tap_a: assert property (first_stage_out == stage_out[0]) else $error("tap");
  last_tap_a: assert property (last_stage_out == stage_out[7]) else $error("tap");
  clear_now_a: assert property (!clear_n |-> !stage_out) else $error("clr");
  clear_flush_a: assert property ($rose(clear_n) |-> !stage_out) else $error("clr");
  hold_keep_a: assert property (clock_hold ##1 clear_n |-> $stable(stage_out))
    else $error("hold");
  shift_step_a: assert property (sh ##1 clear_n |-> stage_out ==
    {$past(stage_out[6:0]), $past(serial_data_in)}) else $error("shift");
  entry_pair_a: assert property (sh ##1 sh ##1 clear_n |->
    stage_out[1] == $past(serial_data_in, 2)) else $error("entry");
endmodule
bind esr_shift esr_chk chk_u (.*);
`default_nettype wire

// ### bench/esr_src.sv
// word source standing in for the surrounding logic
`timescale 1ns/10ps
`default_nettype none
module esr_src (
  // clock, reset, request
  input wire logic       clk_sys, reset, go,
  input wire logic [7:0] d,
  // fifo fill side
  input wire logic       word_ready,
  output logic           word_valid,
  output logic     [7:0] word_data
);
  always @(posedge clk_sys or posedge reset)
    if (reset) word_valid <= 1'b0;
    else if (word_valid && word_ready) word_valid <= 1'b0;
    else if (go) word_valid <= 1'b1;
  // released data flips so a stale word never looks live
  always @(posedge clk_sys)
    word_data <= go ? d : (word_valid && word_ready ? ~word_data : word_data);
endmodule
`default_nettype wire

// ### bench/esr_tb.sv
// self-checking bench, clocked-load build
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 0, reset = 1, clear_n = 1, shift_enable = 0, shift_load_select = 0;
  logic clock_hold = 0, serial_data_in = 0, go = 0, obs = 0, word_valid, word_ready;
  logic [7:0] d = 0, word_data, stage_out, r = 8'h1c, cur;
  logic [7:0] q[$], wq[$];
  int errors = 0, n_compared = 0, i;
  esr_src src_u (.clk_sys, .reset, .go, .d, .word_ready, .word_valid, .word_data);
  esr_shift dut_u (.clk_sys, .reset, .serial_gate_a(serial_data_in),
    .serial_gate_b(serial_data_in),
    .serial_data_in, .word_valid, .word_ready, .word_data, .shift_enable, .clear_n,
    .clear_high(1'b0), .load_not_shift(1'b1), .clock_inhibit(1'b0), .shift_load_select,
    .clock_hold, .stage_out, .stage_inverted_out(), .first_stage_out(), .last_stage_out());
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, g);
    n_compared++;
    if (e !== g) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one device clock per call; back to back calls keep the enable high
  task automatic st(input logic s, h, b, input logic [7:0] e);
    {shift_load_select, clock_hold, serial_data_in, shift_enable} <= {s, h, b, 1'b1};
    @(posedge clk_sys);
    q.push_back(e);
    obs <= 1'b1;
  endtask
  initial forever #2 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (obs) begin
    obs <= 1'b0;
    cmp("stage_out", q.pop_front(), stage_out);
  end
  initial begin
    #20000;
    errors++;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // nine words: the last one stalls at a full fifo
    for (i = 0; i < 9; i++) begin
      r = lfsr(r);
      wq.push_back(r);
      {go, d} <= {1'b1, r};
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    cmp("word_ready", 8'h00, {7'h00, word_ready});
    st(1'b1, 1'b1, 1'b1, 8'h00);
    for (i = 0; i < 9; i++) st(1'b0, 1'b0, 1'b1, wq[i]);
    cur = wq[8];
    st(1'b0, 1'b0, 1'b0, cur);
    st(1'b0, 1'b1, 1'b0, cur);
    for (i = 0; i < 8; i++) begin
      r = lfsr(r);
      cur = {cur[6:0], r[0]};
      st(1'b1, 1'b0, r[0], cur);
    end
    shift_enable <= 1'b0;
    @(posedge clk_sys);
    clear_n <= 1'b0;
    q.push_back(8'h00);
    obs <= 1'b1;
    @(posedge clk_sys);
    clear_n <= 1'b1;
    st(1'b1, 1'b1, 1'b0, 8'h00);
    @(posedge clk_sys);
    summarize;
  end
endmodule
`default_nettype wire
